// file: dv/tb.sv
// Bench for the uncorrectable error bank
`timescale 1ns/100ps
module tb;
    import uems_pkg::*;
    logic       i_clk = 1'b0;
    logic       i_sys_rst = 1'b1;
    logic       i_link_reset_n = 1'b1;
    logic       i_global_reset_input_n = 1'b1;
    uems_addr_t i_cfg_addr = 12'h000;
    logic       i_cfg_wr = 1'b0;
    logic       i_cfg_rd = 1'b0;
    uems_be_t   i_cfg_be = 4'hf;
    uems_word_t i_cfg_wdata = 32'h0;
    uems_word_t i_err_event = 32'h0;
    uems_word_t o_cfg_rdata;
    logic       o_cfg_rvalid;
    logic       o_err_fatal_msg;
    logic       o_err_nonfatal_msg;
    logic       o_hdr_log_load;
    uems_ptr_t  o_first_err_ptr;
    int         error_cnt = 0;
    int         compares = 0;

    uems_bank uems_bank_i (
        .i_clk                  (i_clk),
        .i_sys_rst              (i_sys_rst),
        .i_link_reset_n         (i_link_reset_n),
        .i_global_reset_input_n (i_global_reset_input_n),
        .i_cfg_addr             (i_cfg_addr),
        .i_cfg_wr               (i_cfg_wr),
        .i_cfg_rd               (i_cfg_rd),
        .i_cfg_be               (i_cfg_be),
        .i_cfg_wdata            (i_cfg_wdata),
        .i_err_event            (i_err_event),
        .o_cfg_rdata            (o_cfg_rdata),
        .o_cfg_rvalid           (o_cfg_rvalid),
        .o_err_fatal_msg        (o_err_fatal_msg),
        .o_err_nonfatal_msg     (o_err_nonfatal_msg),
        .o_hdr_log_load         (o_hdr_log_load),
        .o_first_err_ptr        (o_first_err_ptr)
    );
    always #12.5 i_clk = ~i_clk;
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input uems_addr_t a, input uems_word_t d, input uems_be_t b);
        @(negedge i_clk);
        i_cfg_addr = a;
        i_cfg_wdata = d;
        i_cfg_be = b;
        i_cfg_wr = 1'b1;
        @(negedge i_clk);
        i_cfg_wr = 1'b0;
    endtask
    task automatic rd(input uems_addr_t a, input uems_word_t exp);
        @(negedge i_clk);
        i_cfg_addr = a;
        i_cfg_rd = 1'b1;
        @(negedge i_clk);
        i_cfg_rd = 1'b0;
        chk("rvalid", 32'h1, {31'h0, o_cfg_rvalid});
        chk("rdata", exp, o_cfg_rdata);
    endtask
    task automatic fire(input uems_word_t e, input logic [2:0] exp);
        @(negedge i_clk);
        i_err_event = e;
        @(negedge i_clk);
        i_err_event = 32'h0;
        chk("msgs", {29'h0, exp}, {29'h0, o_err_fatal_msg, o_err_nonfatal_msg, o_hdr_log_load});
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_fields;
        rd(12'h108, 32'h0000_0000);
        rd(12'h10c, 32'h0006_2031);
        rd(12'h200, 32'h0000_0000);
        wr(12'h108, 32'hffff_ffff, 4'hf);
        rd(12'h108, 32'h001f_f010);
        wr(12'h108, 32'h0020_0020, 4'hf);
        rd(12'h108, 32'h0000_0000);
        wr(12'h10c, 32'hffff_ffff, 4'hf);
        rd(12'h10c, 32'h001f_f031);
        wr(12'h10c, 32'h0000_0000, 4'hf);
        rd(12'h10c, 32'h0000_0021);
        wr(12'h10c, 32'hffff_ffff, 4'h4);
        rd(12'h10c, 32'h001f_0021);
    endtask
    task automatic t_events;
        wr(12'h108, 32'h0, 4'hf);
        wr(12'h10c, 32'h0004_0000, 4'hf);
        fire(32'h0004_0000, 3'b101);
        chk("ptr", 32'd18, {27'h0, o_first_err_ptr});
        fire(32'h0000_1000, 3'b010);
        wr(12'h104, 32'h0, 4'hf);
        rd(12'h104, 32'h0004_1000);
        wr(12'h104, 32'h0004_1000, 4'hf);
        rd(12'h104, 32'h0);
        wr(12'h108, 32'h0010_0010, 4'hf);
        fire(32'h0030_0010, 3'b000);
        chk("ptr", 32'd18, {27'h0, o_first_err_ptr});
        rd(12'h104, 32'h0);
    endtask
    task automatic t_pin(input logic glb);
        fire(32'h0000_1000, 3'b011);
        chk("ptr", 32'd12, {27'h0, o_first_err_ptr});
        wr(12'h108, 32'hffff_ffff, 4'hf);
        @(negedge i_clk);
        i_link_reset_n = glb;
        i_global_reset_input_n = !glb;
        repeat (4) @(negedge i_clk);
        i_link_reset_n = 1'b1;
        i_global_reset_input_n = 1'b1;
        repeat (3) @(negedge i_clk);
        rd(12'h108, 32'h0);
        rd(12'h10c, 32'h0006_2031);
        rd(12'h104, 32'h0);
        chk("ptr", 32'd0, {27'h0, o_first_err_ptr});
    endtask
    task automatic close_out;
        $display("Compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        error_cnt++;
        close_out();
    end
    initial begin
        repeat (8) @(negedge i_clk);
        i_sys_rst = 1'b0;
        repeat (3) @(negedge i_clk);
        t_fields();
        t_events();
        t_pin(1'b0);
        t_pin(1'b1);
        close_out();
    end
endmodule // tb

bind uems_bank uems_bank_properties uems_bank_properties_i (
    .i_clk              (i_clk),
    .i_sys_rst          (i_sys_rst),
    .i_cfg_addr         (i_cfg_addr),
    .i_cfg_rd           (i_cfg_rd),
    .i_err_event        (i_err_event),
    .o_cfg_rdata        (o_cfg_rdata),
    .o_cfg_rvalid       (o_cfg_rvalid),
    .o_err_fatal_msg    (o_err_fatal_msg),
    .o_err_nonfatal_msg (o_err_nonfatal_msg),
    .o_hdr_log_load     (o_hdr_log_load),
    .o_first_err_ptr    (o_first_err_ptr)
);

// file: dv/uems_bank_properties.sv
// Port properties of the error bank
`timescale 1ns/100ps
`include "uems_consts.svh"
module uems_bank_properties
    import uems_pkg::*;
(
    input wire logic       i_clk,
    input wire logic       i_sys_rst,
    input wire uems_addr_t i_cfg_addr,
    input wire logic       i_cfg_rd,
    input wire uems_word_t i_err_event,
    input wire uems_word_t o_cfg_rdata,
    input wire logic       o_cfg_rvalid,
    input wire logic       o_err_fatal_msg,
    input wire logic       o_err_nonfatal_msg,
    input wire logic       o_hdr_log_load,
    input wire uems_ptr_t  o_first_err_ptr
);
    localparam uems_word_t RW_BITS = `UEMS_RW_BITS;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    a_read_answer: assert property (
        i_cfg_rd |=> o_cfg_rvalid) else $error("read unanswered");
    a_no_stray_valid: assert property (
        !i_cfg_rd |=> !o_cfg_rvalid) else $error("stray valid");
    a_rdata_holds: assert property (
        !o_cfg_rvalid |-> $stable(o_cfg_rdata)) else $error("rdata moved");
    a_mask_fixed: assert property (
        (o_cfg_rvalid && ($past(i_cfg_addr) == `UEMS_OFS_MASK)) |->
        ((o_cfg_rdata & 32'hffe0_0fef) == 32'h0)) else $error("mask fixed bits");
    a_sev_fixed: assert property (
        (o_cfg_rvalid && ($past(i_cfg_addr) == `UEMS_OFS_SEVERITY)) |->
        ((o_cfg_rdata & 32'hffe0_0fef) == 32'h0000_0021)) else $error("sev fixed bits");
    a_no_cause_quiet: assert property (
        ((i_err_event & RW_BITS) == 32'h0) |=> (!o_err_fatal_msg && !o_err_nonfatal_msg))
        else $error("msg without event");
    a_hdr_with_msg: assert property (
        o_hdr_log_load |-> (o_err_fatal_msg || o_err_nonfatal_msg)) else $error("lone hdr");
    a_ptr_valid: assert property (
        o_hdr_log_load |-> RW_BITS[o_first_err_ptr]) else $error("bad ptr");
    c_fatal: cover property (o_err_fatal_msg);
    c_nonfatal: cover property (o_err_nonfatal_msg);
    c_hdr: cover property (o_hdr_log_load);
endmodule // uems_bank_properties

// file: logic/uems_bank.sv
// Uncorrectable error mask, severity and status register bank
`timescale 1ns/100ps
`include "uems_consts.svh"
module uems_bank
    import uems_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_link_reset_n,
    input  wire logic       i_global_reset_input_n,
    input  wire uems_addr_t i_cfg_addr,
    input  wire logic       i_cfg_wr,
    input  wire logic       i_cfg_rd,
    input  wire uems_be_t   i_cfg_be,
    input  wire uems_word_t i_cfg_wdata,
    input  wire uems_word_t i_err_event,
    output uems_word_t      o_cfg_rdata,
    output logic            o_cfg_rvalid,
    output logic            o_err_fatal_msg,
    output logic            o_err_nonfatal_msg,
    output logic            o_hdr_log_load,
    output uems_ptr_t       o_first_err_ptr
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset pin synchronisers

    logic [1:0] link_sync_reg;
    logic [1:0] global_reset_input_sync_reg;
    logic       bank_rst;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            link_sync_reg <= 2'h0;
        end else begin
            link_sync_reg <= {link_sync_reg[0], i_link_reset_n};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            global_reset_input_sync_reg <= 2'h0;
        end else begin
            global_reset_input_sync_reg <= {global_reset_input_sync_reg[0], i_global_reset_input_n};
        end
    end

    assign bank_rst = i_sys_rst | ~link_sync_reg[1] | ~global_reset_input_sync_reg[1];

    ////////////////////////////////////////////////////////////////////////////
    // Address decode

    logic       hit_status;
    logic       hit_mask;
    logic       hit_sev;
    logic       wr_mask;
    logic       wr_sev;
    logic       wr_status;
    uems_word_t lane_en;

    assign hit_status = (i_cfg_addr == `UEMS_OFS_STATUS);
    assign hit_mask   = (i_cfg_addr == `UEMS_OFS_MASK);
    assign hit_sev    = (i_cfg_addr == `UEMS_OFS_SEVERITY);
    assign lane_en    = {{8{i_cfg_be[3]}}, {8{i_cfg_be[2]}}, {8{i_cfg_be[1]}}, {8{i_cfg_be[0]}}};

    assign wr_mask    = i_cfg_wr & hit_mask;
    assign wr_sev     = i_cfg_wr & hit_sev;
    assign wr_status  = i_cfg_wr & hit_status;

    ////////////////////////////////////////////////////////////////////////////
    // Error positions

    uems_word_t mask_bits;
    uems_word_t sev_bits;
    uems_word_t status_bits;
    uems_word_t record_bits;

    for (genvar g = 0; g < 32; g++) begin : g_pos
        localparam uems_word_t RW_BITS  = `UEMS_RW_BITS;
        localparam uems_word_t SEV_INIT = `UEMS_SEV_RESET;
        if (RW_BITS[g]) begin : g_rw
            uems_err_slice #(
                .SEV_RST (SEV_INIT[g])
            ) u_slice (
                .i_clk        (i_clk),
                .i_rst        (bank_rst),
                .i_mask_wr    (wr_mask & lane_en[g]),
                .i_mask_wdata (i_cfg_wdata[g]),
                .i_sev_wr     (wr_sev & lane_en[g]),
                .i_sev_wdata  (i_cfg_wdata[g]),
                .i_stat_clr   (wr_status & lane_en[g] & i_cfg_wdata[g]),
                .i_event      (i_err_event[g]),
                .o_mask       (mask_bits[g]),
                .o_sev        (sev_bits[g]),
                .o_status     (status_bits[g]),
                .o_record     (record_bits[g])
            );
        end else begin : g_ro
            assign mask_bits[g]   = 1'b0;
            assign sev_bits[g]    = SEV_INIT[g];
            assign status_bits[g] = 1'b0;
            assign record_bits[g] = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Error reporting

    uems_ptr_t first_ptr_reg;
    logic      fatal_reg;
    logic      nonfatal_reg;
    logic      hdr_load_reg;
    logic      any_record;
    uems_ptr_t low_index;

    assign any_record = |record_bits;

    // Lowest recorded index wins
    always_comb begin
        low_index = '0;
        for (int i = 31; i >= 0; i--) begin
            if (record_bits[i]) begin
                low_index = uems_ptr_t'(i);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (bank_rst) begin
            fatal_reg    <= 1'b0;
            nonfatal_reg <= 1'b0;
        end else begin
            fatal_reg    <= |(record_bits & sev_bits);
            nonfatal_reg <= |(record_bits & ~sev_bits);
        end
    end

    // Log and pointer on unmasked first error
    always_ff @(posedge i_clk) begin
        if (bank_rst) begin
            first_ptr_reg <= '0;
            hdr_load_reg  <= 1'b0;
        end else begin
            hdr_load_reg <= any_record & ~(|status_bits);
            if (any_record && !(|status_bits)) begin
                first_ptr_reg <= low_index;
            end
        end
    end

    assign o_err_fatal_msg    = fatal_reg;
    assign o_err_nonfatal_msg = nonfatal_reg;
    assign o_hdr_log_load     = hdr_load_reg;
    assign o_first_err_ptr    = first_ptr_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    uems_word_t rdata_reg;
    logic       rvalid_reg;
    uems_word_t rdata_next;

    always_comb begin
        rdata_next = '0;
        case (i_cfg_addr)
            `UEMS_OFS_STATUS: begin
                rdata_next = status_bits;
            end
            `UEMS_OFS_MASK: begin
                rdata_next = mask_bits;
            end
            `UEMS_OFS_SEVERITY: begin
                rdata_next = sev_bits;
            end
            default: begin
                rdata_next = '0;
            end
        endcase
    end

    // Read answer one cycle later
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rdata_reg  <= '0;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= i_cfg_rd;
            if (i_cfg_rd) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    assign o_cfg_rdata  = rdata_reg;
    assign o_cfg_rvalid = rvalid_reg;

endmodule // uems_bank

// file: logic/uems_consts.svh
// Offsets, field positions and reset values of the uncorrectable error bank
`ifndef UEMS_CONSTS_SVH
`define UEMS_CONSTS_SVH

`define UEMS_OFS_STATUS     12'h104
`define UEMS_OFS_MASK       12'h108
`define UEMS_OFS_SEVERITY   12'h10c

`define UEMS_MASK_RESET     32'h0000_0000
`define UEMS_SEV_RESET      32'h0006_2031
`define UEMS_STATUS_RESET   32'h0000_0000

`define UEMS_RW_BITS        32'h001f_f010
`define UEMS_SEV_FIXED_ONE  32'h0000_0021

`define UEMS_BIT_DLL        4
`define UEMS_BIT_SD         5
`define UEMS_BIT_POISON     12
`define UEMS_BIT_FC         13
`define UEMS_BIT_TIMEOUT    14
`define UEMS_BIT_ABORT      15
`define UEMS_BIT_UNEXP      16
`define UEMS_BIT_OVERRUN    17
`define UEMS_BIT_MALFORMED  18
`define UEMS_BIT_ECRC       19
`define UEMS_BIT_UNSUP      20
`define UEMS_BIT_ACS        21

`define UEMS_PTR_W          5

`endif

// file: logic/uems_err_slice.sv
// One error position: mask, severity and sticky status bit
`timescale 1ns/100ps
module uems_err_slice #(
    parameter bit SEV_RST = 1'b0
) (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_mask_wr,
    input  wire logic i_mask_wdata,
    input  wire logic i_sev_wr,
    input  wire logic i_sev_wdata,
    input  wire logic i_stat_clr,
    input  wire logic i_event,
    output logic      o_mask,
    output logic      o_sev,
    output logic      o_status,
    output logic      o_record
);
    logic mask_reg;
    logic sev_reg;
    logic status_reg;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mask_reg <= 1'b0;
        end else if (i_mask_wr) begin
            mask_reg <= i_mask_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sev_reg <= SEV_RST;
        end else if (i_sev_wr) begin
            sev_reg <= i_sev_wdata;
        end
    end

    assign o_record = i_event & ~mask_reg;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            status_reg <= 1'b0;
        end else if (o_record) begin
            status_reg <= 1'b1;
        end else if (i_stat_clr) begin
            status_reg <= 1'b0;
        end
    end

    assign o_mask   = mask_reg;
    assign o_sev    = sev_reg;
    assign o_status = status_reg;
endmodule // uems_err_slice

// file: logic/uems_pkg.sv
// Types shared by the uncorrectable error bank
package uems_pkg;
    typedef logic [31:0] uems_word_t;
    typedef logic [11:0] uems_addr_t;
    typedef logic [3:0]  uems_be_t;
    typedef logic [4:0]  uems_ptr_t;
endpackage
